/* File: pkg/ras_node_consts.svh */
/*
  Constants for the error record node: group layout, register indexes,
  control, feature, status and misc field positions, widths.
  Assumes it is included once per compilation unit through its guard.
*/
`ifndef RAS_NODE_CONSTS_SVH
`define RAS_NODE_CONSTS_SVH

// group layout: the node owns records 1 and 2; 0 and 3 are empty slots
`define RN_GROUP_RECS  4
`define RN_SEL_W       2
`define RN_NODE_FIRST  2'h1
`define RN_NODE_RECS   2
`define RN_DATA_W      64
`define RN_SYN_W       32
`define RN_TS_W        32
`define RN_CNT_W       8

// register index within a selected record
`define RN_REG_FEAT    3'h0
`define RN_REG_CTRL    3'h1
`define RN_REG_STAT    3'h2
`define RN_REG_SYN     3'h3
`define RN_REG_MISC    3'h4
`define RN_REG_TS      3'h5

// control register bits
`define RN_CTL_EN      0
`define RN_CTL_UE      1
`define RN_CTL_UI      2
`define RN_CTL_FI      3
`define RN_CTL_DUI     4
`define RN_CTL_CFI     5
`define RN_CTL_CI      6
`define RN_CTL_RD      7
`define RN_CTL_WR      8
`define RN_CTL_W       9
`define RN_CTL_RST     9'h000

// feature word of the first record; detection field in [1:0]
`define RN_FEAT_VALUE  64'h0000_0000_0000_01FD

// status and misc fields
`define RN_ST_VALID    0
`define RN_ST_CLS_LO   1
`define RN_MISC_OVF    8
`define RN_MISC_CRIT   9

`endif

/* File: pkg/ras_node_pkg.sv */
/*
  Types shared by the error record node.
  Assumes ras_node_consts.svh is on the include path.
*/
`include "ras_node_consts.svh"

package ras_node_pkg;

  // order gives severity: a later value is more severe
  typedef enum logic [1:0] {
    ERR_NONE,
    ERR_CE,
    ERR_DE,
    ERR_UE
  } err_class_type;

  typedef logic [2:0]              reg_idx_type;
  typedef logic [`RN_SEL_W-1:0]    rec_sel_type;
  typedef logic [`RN_DATA_W-1:0]   data_type;
  typedef logic [`RN_SYN_W-1:0]    syn_type;
  typedef logic [`RN_TS_W-1:0]     ts_type;
  typedef logic [`RN_CNT_W-1:0]    cnt_type;

  typedef struct packed {
    rec_sel_type                          sel;
    logic [`RN_CTL_W-1:0]                 ctrl;
    logic [`RN_NODE_RECS-1:0]             valid;
    err_class_type [`RN_NODE_RECS-1:0]    cls;
    syn_type [`RN_NODE_RECS-1:0]          syn;
    ts_type [`RN_NODE_RECS-1:0]           ts;
    ts_type                               tstamp;
    cnt_type                              cnt;
    logic                                 ovf;
    logic                                 crit;
    data_type                             rdata;
    logic                                 rvalid;
    logic                                 fault_irq;
    logic                                 recov_irq;
    logic                                 crit_irq;
    logic                                 inband;
  } node_state_type;

endpackage

/* File: rtl/ras_error_record_node.sv */
/*
  Error record node with two records inside a four-slot group, its
  feature and control words, a corrected-error counter, timestamps and
  the four error signals.
  Assumes one clock; error events and register accesses are synchronous
  single-cycle strobes; software selects a record before accessing it.
*/
`timescale 1ns/1ps
`include "ras_node_consts.svh"

// Functional notes
// - control bit stops reporting and recording; detection left running
// - fault interrupt, one enable for corrected, another for the rest
// - presettable corrected counter; unsigned wrap is overflow, interrupts
// - each record stores a timestamp beside its syndrome
// - in-band response only for uncorrected, never corrected or deferred
// - recovery interrupt for recorded uncorrected, never corrected errors
// - deferred errors reach recovery interrupt only with deferred enable set
// - critical error condition drives a dedicated critical interrupt
// - a reported error writes its syndrome into an empty or less severe node record
// - first record holds the feature word and the control word
// - all node records share one feature set and one control
// - reporting has separate read and write enables in this node
// - the node holds at least one record
// - node records sit at consecutive group indexes from the first
// - later records: detection field zero, feature and control read zero
// - group index space covers every record of the node
// - unimplemented group slots read zero and ignore writes
// - a more severe error overwrites an unserviced record's syndrome
module ras_error_record_node
(
  // clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_b_i,
  // record select and register access
  input  wire logic                       sel_wr_i,
  input  wire ras_node_pkg::rec_sel_type  sel_data_i,
  input  wire logic                       reg_rd_i,
  input  wire logic                       reg_wr_i,
  input  wire ras_node_pkg::reg_idx_type  reg_idx_i,
  input  wire ras_node_pkg::data_type     reg_wdata_i,
  output logic                            reg_rvalid_o,
  output ras_node_pkg::data_type          reg_rdata_o,
  // error events from the component
  input  wire logic                       err_valid_i,
  input  wire ras_node_pkg::err_class_type err_class_i,
  input  wire logic                       err_rec_i,
  input  wire logic                       err_write_i,
  input  wire logic                       err_req_i,
  input  wire logic                       err_critical_i,
  input  wire ras_node_pkg::syn_type      err_syn_i,
  // error signals
  output logic                            fault_irq_o,
  output logic                            recovery_irq_o,
  output logic                            critical_irq_o,
  output logic                            inband_err_o
);
  import ras_node_pkg::*;

  node_state_type q;
  node_state_type d;

  // slot inside the node's span of the group
  function automatic logic in_node(input rec_sel_type s);
    return (s >= `RN_NODE_FIRST) &&
           (s < `RN_NODE_FIRST + rec_sel_type'(`RN_NODE_RECS));
  endfunction

  function automatic logic loc_of(input rec_sel_type s);
    rec_sel_type t;
    t = s - `RN_NODE_FIRST;
    return t[0];
  endfunction

  logic                  rep;
  logic                  loc;
  logic                  first;
  logic [`RN_CTL_W-1:0]  ctl;

  always_comb begin
    d          = q;
    loc        = loc_of(q.sel);
    first      = (q.sel == `RN_NODE_FIRST);
    ctl        = q.ctrl;
    rep        = 1'b0;
    d.tstamp   = q.tstamp + ts_type'(1);
    d.rvalid   = 1'b0;
    d.inband   = 1'b0;
    if (sel_wr_i) begin
      d.sel = sel_data_i;
    end
    if (reg_rd_i) begin
      d.rvalid = 1'b1;
      d.rdata  = '0;
      if (in_node(q.sel)) begin
        unique case (reg_idx_i)
          `RN_REG_FEAT: d.rdata = first ? `RN_FEAT_VALUE : '0;
          `RN_REG_CTRL: d.rdata = first ? data_type'(q.ctrl) : '0;
          `RN_REG_STAT: begin
            d.rdata[`RN_ST_VALID]                = q.valid[loc];
            d.rdata[`RN_ST_CLS_LO+1:`RN_ST_CLS_LO] = q.cls[loc];
          end
          `RN_REG_SYN:  d.rdata = data_type'(q.syn[loc]);
          `RN_REG_MISC: begin
            if (first) begin
              d.rdata[`RN_CNT_W-1:0] = q.cnt;
              d.rdata[`RN_MISC_OVF]  = q.ovf;
              d.rdata[`RN_MISC_CRIT] = q.crit;
            end
          end
          `RN_REG_TS:   d.rdata = data_type'(q.ts[loc]);
          default:      d.rdata = '0;
        endcase
      end
    end
    // writes to empty slots fall through untouched
    if (reg_wr_i && in_node(q.sel)) begin
      unique case (reg_idx_i)
        `RN_REG_CTRL: begin
          if (first) begin
            d.ctrl = reg_wdata_i[`RN_CTL_W-1:0];
          end
        end
        `RN_REG_STAT: begin
          if (reg_wdata_i[`RN_ST_VALID]) begin
            d.valid[loc] = 1'b0;
            d.cls[loc]   = ERR_NONE;
          end
        end
        `RN_REG_MISC: begin
          if (first) begin
            d.cnt = reg_wdata_i[`RN_CNT_W-1:0];
            if (reg_wdata_i[`RN_MISC_OVF]) begin
              d.ovf = 1'b0;
            end
            if (reg_wdata_i[`RN_MISC_CRIT]) begin
              d.crit = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // error capture after clears, so a new event wins over a clear
    rep = err_valid_i && (err_class_i != ERR_NONE) && ctl[`RN_CTL_EN] &&
          (err_write_i ? ctl[`RN_CTL_WR] : ctl[`RN_CTL_RD]);
    if (rep) begin
      if (!d.valid[err_rec_i] || (err_class_i > d.cls[err_rec_i])) begin
        d.valid[err_rec_i] = 1'b1;
        d.cls[err_rec_i]   = err_class_i;
        d.syn[err_rec_i]   = err_syn_i;
        d.ts[err_rec_i]    = q.tstamp;
      end
      if (err_class_i == ERR_CE) begin
        d.cnt = d.cnt + cnt_type'(1);
        if (d.cnt == '0) begin
          d.ovf = 1'b1;
        end
      end
      if (err_critical_i) begin
        d.crit = 1'b1;
      end
      if (err_req_i && (err_class_i == ERR_UE) && ctl[`RN_CTL_UE]) begin
        d.inband = 1'b1;
      end
    end
    // interrupts are levels built from the next state
    d.fault_irq = 1'b0;
    d.recov_irq = 1'b0;
    for (int i = 0; i < `RN_NODE_RECS; i++) begin
      if (d.valid[i] && (d.cls[i] == ERR_CE) && d.ctrl[`RN_CTL_CFI]) begin
        d.fault_irq = 1'b1;
      end
      if (d.valid[i] && (d.cls[i] != ERR_CE) && d.ctrl[`RN_CTL_FI]) begin
        d.fault_irq = 1'b1;
      end
      if (d.valid[i] && (d.cls[i] == ERR_UE) && d.ctrl[`RN_CTL_UI]) begin
        d.recov_irq = 1'b1;
      end
      if (d.valid[i] && (d.cls[i] == ERR_DE) && d.ctrl[`RN_CTL_UI] &&
          d.ctrl[`RN_CTL_DUI]) begin
        d.recov_irq = 1'b1;
      end
    end
    if (d.ovf && d.ctrl[`RN_CTL_CFI]) begin
      d.fault_irq = 1'b1;
    end
    d.crit_irq = d.crit && d.ctrl[`RN_CTL_CI];
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q      <= '0;
      q.ctrl <= `RN_CTL_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rvalid_o   = q.rvalid;
  assign reg_rdata_o    = q.rdata;
  assign fault_irq_o    = q.fault_irq;
  assign recovery_irq_o = q.recov_irq;
  assign critical_irq_o = q.crit_irq;
  assign inband_err_o   = q.inband;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  logic any_ue;
  logic any_de;
  always_comb begin
    any_ue = 1'b0;
    any_de = 1'b0;
    for (int i = 0; i < `RN_NODE_RECS; i++) begin
      any_ue = any_ue | (q.valid[i] && (q.cls[i] == ERR_UE));
      any_de = any_de | (q.valid[i] && (q.cls[i] == ERR_DE));
    end
  end

  sequence s_ce_wrap;
    rep && (err_class_i == ERR_CE) && (q.cnt == '1) &&
    !(reg_wr_i && (reg_idx_i == `RN_REG_MISC));
  endsequence

  sequence s_read_empty;
    reg_rd_i && !sel_wr_i && !in_node(q.sel);
  endsequence

  a_inband_ue_only: assert property (inband_err_o |->
    $past(err_valid_i && err_req_i && err_class_i == ERR_UE && rep))
    else $error("in-band response without uncorrected error");
  a_recovery_class: assert property (recovery_irq_o |->
    any_ue || any_de)
    else $error("recovery interrupt without uncorrected record");
  a_deferred_gate: assert property (recovery_irq_o && !any_ue |->
    q.ctrl[`RN_CTL_DUI]) else $error("deferred raised recovery ungated");
  a_fault_enable: assert property (fault_irq_o |->
    q.ctrl[`RN_CTL_FI] || q.ctrl[`RN_CTL_CFI])
    else $error("fault interrupt with both enables off");
  a_counter_wrap: assert property (s_ce_wrap |=> q.ovf && q.cnt == '0)
    else $error("counter wrap did not flag overflow");
  a_overflow_sticky: assert property (q.ovf &&
    !(reg_wr_i && reg_idx_i == `RN_REG_MISC) |=> q.ovf)
    else $error("overflow flag dropped without clear");
  a_disabled_quiet: assert property (!q.ctrl[`RN_CTL_EN] && !reg_wr_i
    |=> q.valid == $past(q.valid)) else $error("record written while off");
  a_record_write: assert property (rep && !q.valid[err_rec_i] |=>
    q.valid[$past(err_rec_i)] && q.syn[$past(err_rec_i)] == $past(err_syn_i))
    else $error("reported error not recorded");
  a_severe_overwrite: assert property (rep &&
    err_class_i > q.cls[err_rec_i] |=>
    q.cls[$past(err_rec_i)] == $past(err_class_i))
    else $error("severe error did not overwrite");
  a_empty_slot_zero: assert property (s_read_empty |=>
    reg_rvalid_o && reg_rdata_o == '0) else $error("empty slot read nonzero");
  a_later_feat_zero: assert property (reg_rd_i && in_node(q.sel) &&
    q.sel != `RN_NODE_FIRST && reg_idx_i <= `RN_REG_CTRL |=>
    reg_rdata_o == '0) else $error("later record feature or control nonzero");
  a_critical_raise: assert property (rep && err_critical_i &&
    q.ctrl[`RN_CTL_CI] && !reg_wr_i |=> critical_irq_o)
    else $error("critical interrupt not raised");

  // control writes seen through a slice, since $past wants a plain signal
  logic [`RN_CTL_W-1:0] ctl_wdata;
  assign ctl_wdata = reg_wdata_i[`RN_CTL_W-1:0];

  sequence s_first_ctrl_write;
    reg_wr_i && (q.sel == `RN_NODE_FIRST) && (reg_idx_i == `RN_REG_CTRL);
  endsequence

  sequence s_other_ctrl_write;
    reg_wr_i && (q.sel != `RN_NODE_FIRST) && (reg_idx_i == `RN_REG_CTRL);
  endsequence

  // an event whose access type is switched off must leave no trace
  sequence s_write_blocked;
    err_valid_i && err_write_i && !q.ctrl[`RN_CTL_WR] && !reg_wr_i;
  endsequence

  sequence s_read_blocked;
    err_valid_i && !err_write_i && !q.ctrl[`RN_CTL_RD] && !reg_wr_i;
  endsequence

  a_feature_word: assert property (reg_rd_i &&
    (q.sel == `RN_NODE_FIRST) && (reg_idx_i == `RN_REG_FEAT) |=>
    reg_rdata_o == `RN_FEAT_VALUE) else $error("feature word wrong");
  a_control_shared: assert property (s_first_ctrl_write |=>
    q.ctrl == $past(ctl_wdata)) else $error("node control not written");
  a_control_ignored: assert property (s_other_ctrl_write |=>
    q.ctrl == $past(q.ctrl)) else $error("control changed from other slot");
  a_write_gate: assert property (s_write_blocked |=>
    q.valid == $past(q.valid) && q.cnt == $past(q.cnt))
    else $error("write error reported while write reporting off");
  a_read_gate: assert property (s_read_blocked |=>
    q.valid == $past(q.valid) && q.cnt == $past(q.cnt))
    else $error("read error reported while read reporting off");
  a_inband_never_ce: assert property (rep &&
    (err_class_i != ERR_UE) |=> !inband_err_o)
    else $error("in-band response for corrected or deferred error");
  a_timestamp_store: assert property (rep && !q.valid[err_rec_i] |=>
    q.ts[$past(err_rec_i)] == $past(q.tstamp))
    else $error("record timestamp not stored");
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  a_read_pulse: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without read");
  a_critical_gate: assert property (critical_irq_o |->
    q.crit && q.ctrl[`RN_CTL_CI]) else $error("critical interrupt ungated");

endmodule // ras_error_record_node

/* File: test/err_source_model.sv */
/*
  Component-side error source: presents one error event per call.
  Assumes the bench calls fire() from its own thread, one call at a time.
*/
`timescale 1ns/1ps
module err_source_model
  import ras_node_pkg::*;
(
  // clock
  input  wire logic                        clk_sys_i,
  // error events towards the node
  output logic                             err_valid_o,
  output ras_node_pkg::err_class_type      err_class_o,
  output logic                             err_rec_o,
  output logic                             err_write_o,
  output logic                             err_req_o,
  output logic                             err_critical_o,
  output ras_node_pkg::syn_type            err_syn_o
);
  initial begin
    err_valid_o    = 1'b0;
    err_class_o    = ERR_NONE;
    err_rec_o      = 1'b0;
    err_write_o    = 1'b0;
    err_req_o      = 1'b0;
    err_critical_o = 1'b0;
    err_syn_o      = 32'h0;
  end
  // one-cycle strobe; class and syndrome turn over afterwards so stale values
  // never look like a held event
  task automatic fire(input err_class_type c, input logic r, w, q, k,
                      input syn_type s);
    @(posedge clk_sys_i);
    err_valid_o    <= 1'b1;
    err_class_o    <= c;
    err_rec_o      <= r;
    err_write_o    <= w;
    err_req_o      <= q;
    err_critical_o <= k;
    err_syn_o      <= s;
    @(posedge clk_sys_i);
    err_valid_o <= 1'b0;
    err_class_o <= err_class_type'(~c);
    err_syn_o   <= ~s;
  endtask
endmodule // err_source_model

/* File: test/test_ras_error_record_node.sv */
/*
  Self-checking bench for the error record node.
  Assumes the node answers reads one cycle after the read strobe.
*/
`timescale 1ns/1ps
module test_ras_error_record_node;
  import ras_node_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic          sel_wr_i = 1'b0;
  rec_sel_type   sel_data_i = 2'h0;
  logic          reg_rd_i = 1'b0;
  logic          reg_wr_i = 1'b0;
  reg_idx_type   reg_idx_i = 3'h0;
  data_type      reg_wdata_i = 64'h0;
  logic          reg_rvalid_o;
  data_type      reg_rdata_o;
  logic          ev_v, ev_r, ev_w, ev_q, ev_k;
  err_class_type ev_c;
  syn_type       ev_s;
  logic          f_o, r_o, c_o, i_o;
  int            err_count = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  data_type      ts_e;

  always #2 clk_sys_i = ~clk_sys_i;

  err_source_model i_src (.clk_sys_i(clk_sys_i), .err_valid_o(ev_v),
    .err_class_o(ev_c), .err_rec_o(ev_r), .err_write_o(ev_w),
    .err_req_o(ev_q), .err_critical_o(ev_k), .err_syn_o(ev_s));

  ras_error_record_node i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .sel_wr_i(sel_wr_i), .sel_data_i(sel_data_i), .reg_rd_i(reg_rd_i),
    .reg_wr_i(reg_wr_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
    .reg_rvalid_o(reg_rvalid_o), .reg_rdata_o(reg_rdata_o),
    .err_valid_i(ev_v), .err_class_i(ev_c), .err_rec_i(ev_r),
    .err_write_i(ev_w), .err_req_i(ev_q), .err_critical_i(ev_k),
    .err_syn_i(ev_s), .fault_irq_o(f_o), .recovery_irq_o(r_o),
    .critical_irq_o(c_o), .inband_err_o(i_o));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input data_type s, input data_type e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic pick(input rec_sel_type s);
    @(posedge clk_sys_i);
    sel_wr_i   <= 1'b1;
    sel_data_i <= s;
    @(posedge clk_sys_i);
    sel_wr_i <= 1'b0;
  endtask

  task automatic wr(input rec_sel_type s, input reg_idx_type i,
                    input data_type d);
    pick(s);
    reg_wr_i    <= 1'b1;
    reg_idx_i   <= i;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input rec_sel_type s, input reg_idx_type i,
                    input data_type e);
    pick(s);
    reg_rd_i  <= 1'b1;
    reg_idx_i <= i;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rvalid", {63'h0, reg_rvalid_o}, 64'h1);
    chk("rdata", reg_rdata_o, e);
  endtask

  // fault, recovery, critical, in-band, sampled after the event edge
  task automatic irq(input logic [3:0] e);
    #1;
    chk("irqs", {60'h0, f_o, r_o, c_o, i_o}, {60'h0, e});
  endtask

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(2'h1, 3'h0, 64'h1FD);
    wr(2'h2, 3'h1, '1);
    rd(2'h2, 3'h1, 64'h0);
    rd(2'h2, 3'h0, 64'h0);
    wr(2'h3, 3'h1, '1);
    rd(2'h3, 3'h0, 64'h0);
    rd(2'h0, 3'h1, 64'h0);
    i_src.fire(ERR_UE, 1'b0, 1'b0, 1'b1, 1'b0, 32'hDEAD_0001);
    irq(4'b0000);
    rd(2'h1, 3'h2, 64'h0);
    wr(2'h1, 3'h1, 64'h1FF);
    rd(2'h1, 3'h1, 64'h1FF);
    i_src.fire(ERR_CE, 1'b0, 1'b0, 1'b1, 1'b0, 32'hA5A5_0001);
    irq(4'b1000);
    rd(2'h1, 3'h2, 64'h3);
    rd(2'h1, 3'h3, 64'hA5A5_0001);
    i_src.fire(ERR_UE, 1'b0, 1'b0, 1'b1, 1'b0, 32'h5A5A_0002);
    irq(4'b1101);
    rd(2'h1, 3'h3, 64'h5A5A_0002);
    wr(2'h1, 3'h2, 64'h1);
    irq(4'b0000);
    wr(2'h1, 3'h1, 64'h1EF);
    i_src.fire(ERR_DE, 1'b1, 1'b0, 1'b1, 1'b0, 32'hC0DE_0003);
    irq(4'b1000);
    rd(2'h2, 3'h2, 64'h5);
    wr(2'h1, 3'h1, 64'h1FF);
    @(posedge clk_sys_i);
    irq(4'b1100);
    wr(2'h2, 3'h2, 64'h1);
    wr(2'h1, 3'h1, 64'h0FF);
    i_src.fire(ERR_UE, 1'b0, 1'b1, 1'b1, 1'b0, 32'hBAD0_0004);
    irq(4'b0000);
    rd(2'h1, 3'h2, 64'h0);
    wr(2'h1, 3'h1, 64'h1FF);
    wr(2'h1, 3'h4, 64'hFF);
    i_src.fire(ERR_CE, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0005);
    irq(4'b1000);
    rd(2'h1, 3'h4, 64'h100);
    wr(2'h1, 3'h2, 64'h1);
    rd(2'h1, 3'h4, 64'h100);
    wr(2'h1, 3'h4, 64'h100);
    rd(2'h1, 3'h4, 64'h0);
    i_src.fire(ERR_CE, 1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_0006);
    irq(4'b1010);
    // stamp holds the count before the event edge; it starts after release
    ts_e = data_type'(cycles - 11);
    rd(2'h1, 3'h4, 64'h201);
    rd(2'h2, 3'h5, ts_e);
    give_verdict();
  end
endmodule // test_ras_error_record_node
